/* File: logic/ets_pkg.sv */
// Package for the event transfer server: control block layout, mode codes,
// register offsets and reset values.
// Assumes a 32-bit APB slave and byte-wide internal memory.
`default_nettype none
package ets_pkg;
  // Control block byte offsets
  localparam logic [7:0] CB_CONTROL_OFS = 8'h00;
  localparam logic [7:0] CB_COUNT_OFS = 8'h01;
  localparam logic [7:0] CB_SOURCE_LO_OFS = 8'h02;
  localparam logic [7:0] CB_SOURCE_HI_OFS = 8'h03;
  localparam logic [7:0] CB_DEST_LO_OFS = 8'h04;
  localparam logic [7:0] CB_DEST_HI_OFS = 8'h05;
  localparam logic [7:0] CB_BLOCK_SIZE_OFS = 8'h06;
  // Control byte fields
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 5;
  localparam int CTL_SRC_STEP_BIT = 1;
  localparam int CTL_SRC_UPDATE_BIT = 3;
  // Mode codes
  typedef enum logic [2:0] {
    MODE_BLOCK = 3'h0,
    MODE_TIMED_OUT = 3'h1,
    MODE_CAPTURE = 3'h3,
    MODE_SINGLE = 3'h4,
    MODE_SCAN = 3'h6
  } mode_t;
  // APB register byte addresses
  localparam logic [7:0] REG_STATUS_WORD = 8'h00;
  localparam logic [7:0] REG_CB_BASE = 8'h04;
  localparam logic [7:0] REG_COMMAND = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0c;
  localparam logic [7:0] REG_LAST = 8'h10;
  // Status word: bit 2 is the server enable bit
  localparam int SERVER_ENABLE_POS = 2;
  localparam logic [7:0] STATUS_WORD_RST = 8'h00;
  localparam logic [15:0] CB_BASE_RST = 16'h0000;
  // Command codes written to the command register
  localparam logic [1:0] CMD_SERVER_ON = 2'h1;
  localparam logic [1:0] CMD_SERVER_OFF = 2'h2;
  localparam logic [1:0] CMD_SAVE_CTX = 2'h3;
endpackage
`default_nettype wire

/* File: logic/mem_port_if.sv */
// Byte memory port between the server core and its address stepper.
// Assumes one-cycle read latency memory.
`default_nettype none
interface mem_port_if;
  logic [15:0] src;
  logic step;
  logic [15:0] nxt;
  modport core (output src, output step, input nxt);
  modport stepper (input src, input step, output nxt);
endinterface
`default_nettype wire

/* File: logic/ptr_stepper.sv */
// Source pointer stepper: next pointer value, stepped or held.
// Assumes combinational use by the server core.
`default_nettype none
module ptr_stepper (
  // Pointer port
  mem_port_if.stepper mp
);
  // Step by one byte when asked
  always_comb begin
    mp.nxt = mp.step ? mp.src + 16'h0001 : mp.src;
  end
endmodule
`default_nettype wire

/* File: logic/event_transfer_server.sv */
// Event transfer server: answers an interrupt request with a byte transfer
// driven by a control block held in internal memory.
// Assumes one-cycle-latency byte memory and a core that pulses instr_done.
//
// Summary of operation
// [RQ1] Mode from control bits 7..5: 000 block transfer, 100 single transfer.
// [RQ2] Mode 001 timed output, 011 input capture, 110 converter scan.
// [RQ3] Source pointer used only in single, block and timed-output modes.
// [RQ4] Single mode: control bits 1 and 3 together decide pointer increment.
// [RQ5] Block mode: pointer steps after each transfer only if bit 1 set.
// [RQ6] Block mode end: bit 3 keeps final pointer, else restores start.
// [RQ7] Timed-output mode: pointer written back only when bit 3 set.
// [RQ8] Block size fetched from control block byte offset 6.
// [RQ9] Transfers only while enable bit set; context save clears status word.
// [RQ10] Server on/off command blocks acknowledge until next instruction done.
// [RQ11] Reserved mode codes perform no transfer.
`default_nettype none
module event_transfer_server (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt side
  input wire logic int_req,
  input wire logic instr_done,
  output logic int_ack,
  output logic xfer_done,
  // Memory side
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_RD_CTL = 4'h1, ST_RD_CNT = 4'h2, ST_RD_SLO = 4'h3,
    ST_RD_SHI = 4'h4, ST_RD_DLO = 4'h5, ST_RD_DHI = 4'h6, ST_RD_BLK = 4'h7,
    ST_RD_DATA = 4'h8, ST_WR_DATA = 4'h9, ST_WB_SLO = 4'ha, ST_WB_SHI = 4'hb,
    ST_WB_CNT = 4'hc, ST_DONE = 4'hd
  } state_t;

  state_t state_r;
  logic [7:0] status_word_r;
  logic [15:0] cb_base_r;
  logic [7:0] ctl_r;
  logic [7:0] count_r;
  logic [7:0] blk_r;
  logic [15:0] src_r;
  logic [15:0] src_start_r;
  logic [15:0] dst_r;
  logic [7:0] data_r;
  logic block_ack_r;
  logic [7:0] xfer_total_r;
  logic rd_pending_r;
  mem_port_if mp ();

  ptr_stepper u_stepper (
    .mp(mp)
  );

  // Mode decode of a control byte
  function automatic logic [2:0] mode_of(input logic [7:0] c);
    return c[ets_pkg::MODE_MSB:ets_pkg::MODE_LSB]; // see [RQ1] see [RQ2]
  endfunction

  // Modes that use the source pointer
  function automatic logic uses_src(input logic [7:0] c);
    return (mode_of(c) == ets_pkg::MODE_BLOCK) || (mode_of(c) == ets_pkg::MODE_SINGLE) ||
      (mode_of(c) == ets_pkg::MODE_TIMED_OUT); // see [RQ3]
  endfunction

  logic mode_block;
  logic mode_single;
  logic mode_timed;
  logic step_bit;
  logic upd_bit;
  logic apb_wr;
  logic [15:0] cb_addr;
  assign mode_block = mode_of(ctl_r) == ets_pkg::MODE_BLOCK;
  assign mode_single = mode_of(ctl_r) == ets_pkg::MODE_SINGLE;
  assign mode_timed = mode_of(ctl_r) == ets_pkg::MODE_TIMED_OUT;
  assign step_bit = ctl_r[ets_pkg::CTL_SRC_STEP_BIT];
  assign upd_bit = ctl_r[ets_pkg::CTL_SRC_UPDATE_BIT];
  assign apb_wr = psel && penable && pwrite;

  // Pointer stepping per mode
  always_comb begin
    mp.src = src_r;
    mp.step = 1'b0;
    if (mode_block) begin
      mp.step = step_bit; // see [RQ5]
    end else if (mode_single) begin
      mp.step = step_bit && upd_bit; // see [RQ4]
    end else if (mode_timed) begin
      mp.step = 1'b1;
    end
  end

  // Memory address per state
  always_comb begin
    cb_addr = cb_base_r;
    case (state_r)
      ST_RD_CTL: cb_addr = cb_base_r + 16'(ets_pkg::CB_CONTROL_OFS);
      ST_RD_CNT, ST_WB_CNT: cb_addr = cb_base_r + 16'(ets_pkg::CB_COUNT_OFS);
      ST_RD_SLO, ST_WB_SLO: cb_addr = cb_base_r + 16'(ets_pkg::CB_SOURCE_LO_OFS);
      ST_RD_SHI, ST_WB_SHI: cb_addr = cb_base_r + 16'(ets_pkg::CB_SOURCE_HI_OFS);
      ST_RD_DLO: cb_addr = cb_base_r + 16'(ets_pkg::CB_DEST_LO_OFS);
      ST_RD_DHI: cb_addr = cb_base_r + 16'(ets_pkg::CB_DEST_HI_OFS);
      ST_RD_BLK: cb_addr = cb_base_r + 16'(ets_pkg::CB_BLOCK_SIZE_OFS); // see [RQ8]
      ST_RD_DATA: cb_addr = src_r;
      ST_WR_DATA: cb_addr = dst_r;
      default: cb_addr = cb_base_r;
    endcase
  end

  // Transfer sequencer: one memory read per two cycles (issue, capture), one memory write per cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      rd_pending_r <= 1'b0;
      ctl_r <= 8'h00;
      count_r <= 8'h00;
      blk_r <= 8'h00;
      src_r <= 16'h0000;
      src_start_r <= 16'h0000;
      dst_r <= 16'h0000;
      data_r <= 8'h00;
      xfer_total_r <= 8'h00;
    end else if (state_r != ST_IDLE && state_r != ST_DONE && !rd_pending_r &&
                 state_r <= ST_RD_DATA) begin
      rd_pending_r <= 1'b1;
    end else begin
      rd_pending_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (int_req && status_word_r[ets_pkg::SERVER_ENABLE_POS] && !block_ack_r) begin
            state_r <= ST_RD_CTL; // see [RQ9]
          end
        end
        ST_RD_CTL: begin
          ctl_r <= mem_rdata;
          case (mode_of(mem_rdata))
            ets_pkg::MODE_BLOCK, ets_pkg::MODE_SINGLE, ets_pkg::MODE_TIMED_OUT:
              state_r <= ST_RD_CNT;
            default: state_r <= ST_DONE; // see [RQ11]
          endcase
        end
        ST_RD_CNT: begin
          count_r <= mem_rdata;
          state_r <= uses_src(ctl_r) ? ST_RD_SLO : ST_DONE; // see [RQ3]
        end
        ST_RD_SLO: begin
          src_r[7:0] <= mem_rdata;
          state_r <= ST_RD_SHI;
        end
        ST_RD_SHI: begin
          src_r[15:8] <= mem_rdata;
          src_start_r <= {mem_rdata, src_r[7:0]};
          state_r <= ST_RD_DLO;
        end
        ST_RD_DLO: begin
          dst_r[7:0] <= mem_rdata;
          state_r <= ST_RD_DHI;
        end
        ST_RD_DHI: begin
          dst_r[15:8] <= mem_rdata;
          state_r <= mode_block ? ST_RD_BLK : ST_RD_DATA;
          blk_r <= 8'h01;
        end
        ST_RD_BLK: begin
          blk_r <= (mem_rdata == 8'h00) ? 8'h01 : mem_rdata;
          state_r <= ST_RD_DATA;
        end
        ST_RD_DATA: begin
          data_r <= mem_rdata;
          state_r <= ST_WR_DATA;
        end
        ST_WR_DATA: begin
          xfer_total_r <= xfer_total_r + 8'h01;
          if (mode_block && blk_r != 8'h01) begin
            blk_r <= blk_r - 8'h01;
            src_r <= mp.nxt; // see [RQ5]
            dst_r <= dst_r + 16'h0001;
            state_r <= ST_RD_DATA;
          end else if (mode_block) begin
            src_r <= upd_bit ? mp.nxt : src_start_r; // see [RQ6]
            state_r <= ST_WB_SLO;
          end else if (mode_timed) begin
            src_r <= mp.nxt;
            state_r <= upd_bit ? ST_WB_SLO : ST_WB_CNT; // see [RQ7]
          end else begin
            src_r <= mp.nxt; // see [RQ4]
            state_r <= ST_WB_SLO;
          end
        end
        ST_WB_SLO: state_r <= ST_WB_SHI;
        ST_WB_SHI: state_r <= ST_WB_CNT;
        ST_WB_CNT: begin
          count_r <= count_r - 8'h01;
          state_r <= ST_DONE;
        end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Memory strobes, registered
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      mem_addr <= cb_addr;
      mem_rd <= !rd_pending_r && state_r != ST_IDLE && state_r <= ST_RD_DATA &&
        state_r != ST_DONE;
      mem_wr <= !rd_pending_r && (state_r >= ST_WR_DATA) && (state_r <= ST_WB_CNT);
      case (state_r)
        ST_WB_SLO: mem_wdata <= src_r[7:0];
        ST_WB_SHI: mem_wdata <= src_r[15:8];
        ST_WB_CNT: mem_wdata <= count_r - 8'h01;
        default: mem_wdata <= data_r;
      endcase
    end
  end

  // Interrupt side outputs and acknowledge hold-off
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      xfer_done <= 1'b0;
      int_ack <= 1'b0;
      block_ack_r <= 1'b0;
    end else begin
      xfer_done <= (state_r == ST_DONE);
      int_ack <= (state_r == ST_DONE) ||
        (int_req && !block_ack_r && state_r == ST_IDLE &&
         !status_word_r[ets_pkg::SERVER_ENABLE_POS]);
      if (apb_wr && paddr == ets_pkg::REG_COMMAND &&
          (pwdata[1:0] == ets_pkg::CMD_SERVER_ON || pwdata[1:0] == ets_pkg::CMD_SERVER_OFF)) begin
        block_ack_r <= 1'b1; // see [RQ10]
      end else if (instr_done) begin
        block_ack_r <= 1'b0; // see [RQ10]
      end
    end
  end

  // Software registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_word_r <= ets_pkg::STATUS_WORD_RST;
      cb_base_r <= ets_pkg::CB_BASE_RST;
    end else if (apb_wr) begin
      case (paddr)
        ets_pkg::REG_STATUS_WORD: status_word_r <= pwdata[7:0];
        ets_pkg::REG_CB_BASE: cb_base_r <= pwdata[15:0];
        ets_pkg::REG_COMMAND: begin
          case (pwdata[1:0])
            ets_pkg::CMD_SERVER_ON: status_word_r[ets_pkg::SERVER_ENABLE_POS] <= 1'b1;
            ets_pkg::CMD_SERVER_OFF: status_word_r[ets_pkg::SERVER_ENABLE_POS] <= 1'b0;
            ets_pkg::CMD_SAVE_CTX: status_word_r <= 8'h00; // see [RQ9]
            default: status_word_r <= status_word_r;
          endcase
        end
        default: cb_base_r <= cb_base_r;
      endcase
    end
  end

  // APB answer: zero wait states, error on unmapped address
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr >= ets_pkg::REG_LAST || paddr[1:0] != 2'h0);
      case (paddr)
        ets_pkg::REG_STATUS_WORD: prdata <= {24'h0, status_word_r};
        ets_pkg::REG_CB_BASE: prdata <= {16'h0, cb_base_r};
        ets_pkg::REG_STATE: prdata <= {xfer_total_r, ctl_r, 3'h0, block_ack_r, state_r, blk_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: bench/mem_model.sv */
// Byte memory model on the far side of the transfer server.
// Assumes read data is taken at the clock edge that ends the read strobe.
`default_nettype none
module mem_model (
  // Clock
  input wire logic sys_clk,
  // Memory port
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] m [0:255];
  logic [7:0] last_r = 8'h00;
  // Read data stands while the strobe is high, else the inverse of the last read
  assign mem_rdata = mem_rd ? m[mem_addr[7:0]] : ~last_r;
  // Last read byte and write port
  always @(posedge sys_clk) begin
    if (mem_rd) last_r <= m[mem_addr[7:0]];
    if (mem_wr) m[mem_addr[7:0]] <= mem_wdata;
  end
endmodule
`default_nettype wire

/* File: bench/event_transfer_server_properties.sv */
// Port checker for the event transfer server.
// Assumes it is bound to the server top module.
`default_nettype none
module event_transfer_server_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt and memory side
  input wire logic instr_done,
  input wire logic int_ack,
  input wire logic xfer_done,
  input wire logic mem_rd,
  input wire logic mem_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_acc;
  logic cmd_on_off;
  logic en_r;
  // Completed writes and on/off commands
  assign wr_acc = psel & penable & pready & pwrite;
  assign cmd_on_off = wr_acc && paddr == ets_pkg::REG_COMMAND && pwdata[1] != pwdata[0];
  // Mirror of the server enable bit
  always_ff @(posedge sys_clk) begin
    if (!rst_n) en_r <= 1'b0;
    else if (wr_acc && paddr == ets_pkg::REG_STATUS_WORD) en_r <= pwdata[2];
    else if (wr_acc && paddr == ets_pkg::REG_COMMAND && pwdata[1:0] != 2'h0)
      en_r <= pwdata[1:0] == ets_pkg::CMD_SERVER_ON;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no pready in access phase");
  AST_UNMAPPED: assert property (pready && paddr > ets_pkg::REG_STATE |-> pslverr)
    else $error("unmapped access without pslverr");
  AST_XFER_ENABLED: assert property (xfer_done |-> en_r)
    else $error("transfer while server disabled");
  AST_WR_ENABLED: assert property (mem_wr |-> en_r && !mem_rd)
    else $error("memory write while server disabled");
  AST_ACK_FOLLOWS: assert property (xfer_done |-> ##[0:2] int_ack)
    else $error("no acknowledge after transfer");
  AST_HOLD_OFF: assert property (cmd_on_off ##1 (!instr_done)[*4] |-> !int_ack)
    else $error("acknowledge before next instruction");
  AST_RD_PULSE: assert property (mem_rd |=> !mem_rd)
    else $error("read strobe longer than one cycle");
endmodule
bind event_transfer_server event_transfer_server_properties i_props (.sys_clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .instr_done, .int_ack, .xfer_done,
  .mem_rd, .mem_wr);
`default_nettype wire

/* File: bench/event_transfer_server_tb.sv */
// Self-checking testbench for the event transfer server.
// Assumes the memory model and the bound port checker.
`default_nettype none
module event_transfer_server_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, psel, penable, pwrite, int_req, instr_done;
  logic pready, pslverr, int_ack, xfer_done, mem_rd, mem_wr;
  logic [7:0] paddr, mem_wdata, mem_rdata;
  logic [31:0] pwdata, prdata;
  logic [15:0] mem_addr;
  logic [32:0] wq [$];
  logic [32:0] rq [$];
  logic [32:0] e;
  int mismatches, checked;
  logic [7:0] modes [12] = '{8'h8a, 8'h82, 8'h28, 8'h20, 8'h0a, 8'h02, 8'h08, 8'h60, 8'hc0,
    8'h40, 8'he0, 8'ha0};
  event_transfer_server i_event_transfer_server (.sys_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .int_req, .instr_done, .int_ack, .xfer_done,
    .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  mem_model i_mem_model (.sys_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  // Compare one value
  task automatic cmp(input string s, input logic [32:0] x, input logic [32:0] g);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", s, x, g);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic er, input logic [31:0] v);
    rq.push_back({er, v});
    apb(1'b0, a, 32'h0);
  endtask
  // Control block at 0x40, one request, expected writes noted
  task automatic run(input logic [7:0] c, input logic on);
    logic [7:0] cb [8];
    logic [7:0] v;
    logic [7:0] s;
    logic a;
    logic x;
    logic d;
    logic w;
    int k;
    v = 8'($urandom);
    k = (c[7:5] == 3'h0) ? 3 : 1;
    cb = '{c, 8'h05, 8'h80, 8'h00, 8'hc0, 8'h00, 8'(k), 8'h03};
    foreach (cb[i]) i_mem_model.m[8'h40 + i] = cb[i];
    for (int i = 0; i < 3; i++) i_mem_model.m[8'h80 + i] = v + 8'(i);
    s = 8'h80;
    w = 1'b1;
    if (c[7:5] == 3'h4) s = 8'h80 + 8'(c[1] & c[3]);
    if (c[7:5] == 3'h1) {w, s} = {c[3], 8'h81};
    if (c[7:5] == 3'h0 && c[3]) s = 8'h80 + 8'(k * c[1]);
    if (on && (c[7:5] == 3'h4 || c[7:5] == 3'h1 || c[7:5] == 3'h0)) begin
      for (int i = 0; i < k; i++) wq.push_back({17'hc0 + 17'(i), v + 8'(i * c[1])});
      if (w) wq.push_back({25'h0000042, s});
      if (w) wq.push_back({25'h0000043, 8'h00});
      wq.push_back({25'h0000041, 8'h04});
    end
    int_req <= 1'b1;
    a = 1'b0;
    d = 1'b0;
    for (int n = 0; n < 200 && !a; n++) begin
      @(negedge sys_clk);
      a = int_ack === 1'b1;
      d = d || xfer_done === 1'b1;
      x = mem_rd === 1'b1;
      @(posedge sys_clk);
      instr_done <= n == 8;
      if (x || a) int_req <= 1'b0;
    end
    @(posedge sys_clk);
    instr_done <= 1'b0;
    if (!a) mismatches++;
    cmp("xfer_done", 33'(on), 33'(d));
  endtask
  // Oldest note against each memory write and read answer
  always @(posedge sys_clk) begin
    if (mem_wr === 1'b1) cmp("mem write", wq.size() ? wq.pop_front() : '1,
      {9'h0, mem_addr, mem_wdata});
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = rq.pop_front();
      cmp("apb read", e, {pslverr, prdata});
    end
  end
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_sim;
  end
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, int_req, instr_done, paddr, pwdata} = '0;
    mismatches = 0;
    checked = 0;
    void'($urandom(97));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ets_pkg::REG_STATUS_WORD, 1'b0, {24'h0, ets_pkg::STATUS_WORD_RST});
    rd(ets_pkg::REG_CB_BASE, 1'b0, {16'h0, ets_pkg::CB_BASE_RST});
    rd(8'h20, 1'b1, 32'h0);
    rd(8'h05, 1'b1, 32'h0);
    run(8'h8a, 1'b0);
    apb(1'b1, ets_pkg::REG_CB_BASE, 32'h40);
    apb(1'b1, ets_pkg::REG_STATUS_WORD, 32'h4);
    rd(ets_pkg::REG_STATUS_WORD, 1'b0, 32'h4);
    foreach (modes[i]) run(modes[i], 1'b1);
    apb(1'b1, ets_pkg::REG_COMMAND, {30'h0, ets_pkg::CMD_SAVE_CTX});
    rd(ets_pkg::REG_STATUS_WORD, 1'b0, 32'h0);
    run(8'h8a, 1'b0);
    apb(1'b1, ets_pkg::REG_COMMAND, {30'h0, ets_pkg::CMD_SERVER_ON});
    run(8'h82, 1'b1);
    apb(1'b1, ets_pkg::REG_COMMAND, {30'h0, ets_pkg::CMD_SERVER_OFF});
    rd(ets_pkg::REG_STATUS_WORD, 1'b0, 32'h0);
    cmp("pending writes", 33'h0, 33'(wq.size()));
    end_sim;
  end
endmodule
`default_nettype wire
